// File: csp_cfg.svh
//
// Contract
// - four codec wires: bit clock, frame sync, serial in, serial out
// - clock_direction high drives the bit clock from the divisor, else input
// - sync_direction high drives frame sync from frame settings, else input
// - out_float high floats the serial output when it carries no data
// - sync_clock_select picks system clock or bit clock for frame sync
// - loopback feeds outgoing bits to the receiver, ignoring serial input
// - transmitter and receiver each run only while their own enable is set
// - interrupt on transmit or receive FIFO becoming empty or full
// - interrupt on transmit or receive overrun when enabled
// - interrupt when a complete sample is received, apart from FIFO events
// - generated frame sync divides its clock by the 8-bit frame divisor
// - first data bit starts data_delay bit clocks after frame sync
// - generated bit clock divides the system clock by twice (8-bit divisor + 1)
// - tx_edge_sel high shifts out on falling edge, low on rising
// - rx_edge_sel high samples on rising edge, low on falling
// - sync_length high gives one-cycle frame sync, low a square wave
// - word_width_sel high gives 32-bit shift registers, low 16-bit
// - word type selects single, control+data, control+2 data or stereo
// - frames_per_sample sets words per sample and sample-ready level
// - frame sync marks the first bit of a word; input sync is sampled
// - one bit received and one bit sent each bit clock period
// - transmit writes feed the serializer; received words fill receive data
// - status flags set on source rising edge, cleared by status read
// - status bits from 0: tx empty, tx full, rx empty, rx full, ready, tx ovr, rx ovr
// - 32-bit words take two 16-bit writes or reads, high half first
// - generated bit clock has a 50% duty cycle from a counter
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
// register indices, byte address is index times four
`define CSP_IDX_CTRL 16'hec00
`define CSP_IDX_FRM  16'hec02
`define CSP_IDX_SCK  16'hec04
`define CSP_IDX_STS  16'hec06
`define CSP_IDX_TX   16'hec08
`define CSP_IDX_RX   16'hec0a
// reset values
`define CSP_RST_CTRL 16'h0800
`define CSP_RST_FRM  16'h0096
`define CSP_RST_SCK  16'h401f
// codec_control bits
`define CSP_C_TEN  0
`define CSP_C_REN  1
`define CSP_C_ITE  2
`define CSP_C_ITF  3
`define CSP_C_ITO  4
`define CSP_C_IRE  5
`define CSP_C_IRF  6
`define CSP_C_IRS  7
`define CSP_C_IRO  8
`define CSP_C_CLOCK_DIRECTION 9
`define CSP_C_SYNC_DIRECTION 10
`define CSP_C_OUT_FLOAT 11
`define CSP_C_FSC  12
`define CSP_C_LOOP 13
// serial_clock_control bits
`define CSP_S_TES 8
`define CSP_S_RES 9
`define CSP_S_FRL 10
`define CSP_S_DWS 11
`define CSP_S_WT  13:12
`define CSP_S_FPS 15:14
`define CSP_S_SD  7:0
// frame_control fields
`define CSP_F_FD 7:0
`define CSP_F_DD 15:8
// last bit index for each word width
`define CSP_LAST16 5'h0f
`define CSP_LAST32 5'h1f
`endif

// File: csp_pkg.sv
package csp_pkg;
	// frame sequencer states
	typedef enum logic [2:0]
	{
		CSP_IDLE  = 3'b001,
		CSP_DELAY = 3'b010,
		CSP_SHIFT = 3'b100
	} csp_state_t;
	// pin levels into the port
	typedef struct packed
	{
		logic sclk;
		logic fs;
		logic sdi;
	} csp_pin_in_t;
	// pin drives, enables low while driving
	typedef struct packed
	{
		logic sclk;
		logic sclkOeN;
		logic fs;
		logic fsOeN;
		logic sdo;
		logic sdoOeN;
	} csp_pin_out_t;
endpackage : csp_pkg

// File: csp_codec_port.sv
`timescale 1ns/100ps
`include "csp_cfg.svh"
module csp_codec_port #(
	parameter int DEPTH = 4,
	parameter int PTRW  = 2
)(
	// system
	input  wire logic                  clk,
	input  wire logic                  rst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [17:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic      [31:0]           prdata,
	output logic                       pslverr,
	// codec pins
	input  wire csp_pkg::csp_pin_in_t  pinIn,
	output csp_pkg::csp_pin_out_t      pinOut,
	// interrupt request
	output logic                       irq
);
	//--------------------------------------------------
	// declarations
	//--------------------------------------------------
	logic [15:0]         ctrl;
	logic [15:0]         frm;
	logic [15:0]         sck;
	logic [6:0]          flags;
	logic [6:0]          snap;
	logic [6:0]          sets;
	logic [6:0]          prevCond;
	logic [6:0]          cond;
	logic [15:0]         regIdx;
	logic                apbDone;
	logic                mapped;
	logic [31:0]         next_rdata;
	logic [31:0]         txMem [DEPTH];
	logic [31:0]         rxMem [DEPTH];
	logic [PTRW-1:0]     txWr;
	logic [PTRW-1:0]     txRd;
	logic [PTRW-1:0]     rxWr;
	logic [PTRW-1:0]     rxRd;
	logic [PTRW:0]       txCnt;
	logic [PTRW:0]       rxCnt;
	logic                txFull;
	logic                txEmpty;
	logic                rxFull;
	logic                rxEmpty;
	logic                txHalf;
	logic                rxHalf;
	logic [15:0]         txHold;
	logic                txWrite;
	logic                txPush;
	logic                txOvr;
	logic                txPop;
	logic                rxPush;
	logic                rxOvr;
	logic                rxPop;
	logic [31:0]         rxWord;
	logic [7:0]          divCnt;
	logic                genClk;
	logic                bitQ;
	logic                bitPrev;
	logic                bitRise;
	logic                bitFall;
	logic [7:0]          fsCnt;
	logic [7:0]          fdMax;
	logic                fsTick;
	logic                fsGen;
	logic                next_fsGen;
	logic                fsLvl;
	logic                fsSamp;
	logic                frameStart;
	csp_pkg::csp_state_t state;
	logic [7:0]          dlyCnt;
	logic [1:0]          words;
	logic [4:0]          lastBit;
	logic                txEdge;
	logic                rxEdge;
	logic [4:0]          txBit;
	logic [4:0]          rxBit;
	logic [1:0]          txWords;
	logic [1:0]          rxWords;
	logic [31:0]         txShift;
	logic [31:0]         rxShift;
	logic [31:0]         txLoad;
	logic                sdoBit;
	logic                sdoValid;
	logic                rxIn;
	logic [2:0]          fpsLevel;
	logic                inShift;
	logic                txStart;
	logic                rxStep;
	logic                rxLast;

	// ring pointer step
	function automatic logic [PTRW-1:0] csp_inc(input logic [PTRW-1:0] p);
		if (p == PTRW'(DEPTH - 1))
			csp_inc = '0;
		else
			csp_inc = p + 1'b1;
	endfunction : csp_inc

	//--------------------------------------------------
	// control fields
	//--------------------------------------------------
	assign txFull   = (txCnt == (PTRW+1)'(DEPTH));
	assign txEmpty  = (txCnt == '0);
	assign rxFull   = (rxCnt == (PTRW+1)'(DEPTH));
	assign rxEmpty  = (rxCnt == '0);
	assign lastBit  = sck[`CSP_S_DWS] ? `CSP_LAST32 : `CSP_LAST16;
	assign fdMax    = (frm[`CSP_F_FD] == 8'h00) ? 8'h00
	                : frm[`CSP_F_FD] - 8'h01;
	assign fpsLevel = 3'(sck[`CSP_S_FPS]) + 3'h1;
	// words per frame from the word type
	always_comb
	begin
		case (sck[`CSP_S_WT])
			2'h1:    words = 2'h2;
			2'h2:    words = 2'h3;
			default: words = 2'h1;
		endcase
	end

	//--------------------------------------------------
	// apb slave
	//--------------------------------------------------
	assign regIdx  = paddr[17:2];
	assign apbDone = psel & penable & pready;

	// one wait state, answer registered
	always_ff @(posedge clk)
	begin
		if (rst)
			pready <= 1'b0;
		else
			pready <= psel & penable & ~pready;
	end

	// read data mux and address decode
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		mapped     = 1'b1;
		if (regIdx == `CSP_IDX_CTRL)
			next_rdata = {16'h0000, ctrl};
		else if (regIdx == `CSP_IDX_FRM)
			next_rdata = {16'h0000, frm};
		else if (regIdx == `CSP_IDX_SCK)
			next_rdata = {16'h0000, sck};
		else if (regIdx == `CSP_IDX_STS)
			next_rdata = {25'h0, flags};
		else if (regIdx == `CSP_IDX_TX)
			next_rdata = 32'h0000_0000;
		else if (regIdx == `CSP_IDX_RX)
		begin
			if (rxEmpty)
				next_rdata = 32'h0000_0000;
			else if (sck[`CSP_S_DWS] & ~rxHalf)
				next_rdata = {16'h0000, rxMem[rxRd][31:16]};
			else
				next_rdata = {16'h0000, rxMem[rxRd][15:0]};
		end
		else
			mapped = 1'b0;
	end

	// capture read data in the first access cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			snap    <= 7'h00;
		end
		else if (psel & penable & ~pready)
		begin
			prdata  <= next_rdata;
			pslverr <= ~mapped;
			snap    <= flags;
		end
	end

	// control register writes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl <= `CSP_RST_CTRL;
			frm  <= `CSP_RST_FRM;
			sck  <= `CSP_RST_SCK;
		end
		else if (apbDone & pwrite)
		begin
			if (regIdx == `CSP_IDX_CTRL)
				ctrl <= pwdata[15:0];
			else if (regIdx == `CSP_IDX_FRM)
				frm <= pwdata[15:0];
			else if (regIdx == `CSP_IDX_SCK)
				sck <= pwdata[15:0];
		end
	end

	//--------------------------------------------------
	// transmit fifo
	//--------------------------------------------------
	assign txWrite = apbDone & pwrite & (regIdx == `CSP_IDX_TX);
	assign txPush  = txWrite & (~sck[`CSP_S_DWS] | txHalf) & ~txFull;
	assign txOvr   = txWrite & (~sck[`CSP_S_DWS] | txHalf) & txFull;

	// half-word pairing, high half written first
	always_ff @(posedge clk)
	begin
		if (rst | ~sck[`CSP_S_DWS])
		begin
			txHalf <= 1'b0;
			txHold <= 16'h0000;
		end
		else if (txWrite)
		begin
			txHalf <= ~txHalf;
			txHold <= pwdata[15:0];
		end
	end

	// storage and pointers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			txWr  <= '0;
			txRd  <= '0;
			txCnt <= '0;
		end
		else
		begin
			if (txPush)
			begin
				txMem[txWr] <= sck[`CSP_S_DWS] ? {txHold, pwdata[15:0]}
				                               : {16'h0000, pwdata[15:0]};
				txWr <= csp_inc(txWr);
			end
			if (txPop)
				txRd <= csp_inc(txRd);
			txCnt <= txCnt + (PTRW+1)'(txPush) - (PTRW+1)'(txPop);
		end
	end

	//--------------------------------------------------
	// receive fifo
	//--------------------------------------------------
	assign rxPop = apbDone & ~pwrite & (regIdx == `CSP_IDX_RX)
	             & (~sck[`CSP_S_DWS] | rxHalf) & ~rxEmpty;

	// read pairing, high half delivered first
	always_ff @(posedge clk)
	begin
		if (rst | ~sck[`CSP_S_DWS])
			rxHalf <= 1'b0;
		else if (apbDone & ~pwrite & (regIdx == `CSP_IDX_RX) & ~rxEmpty)
			rxHalf <= ~rxHalf;
	end

	// storage and pointers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rxWr  <= '0;
			rxRd  <= '0;
			rxCnt <= '0;
		end
		else
		begin
			if (rxPush)
			begin
				rxMem[rxWr] <= rxWord;
				rxWr        <= csp_inc(rxWr);
			end
			if (rxPop)
				rxRd <= csp_inc(rxRd);
			rxCnt <= rxCnt + (PTRW+1)'(rxPush) - (PTRW+1)'(rxPop);
		end
	end

	//--------------------------------------------------
	// bit clock
	//--------------------------------------------------
	// divider, half period is divisor plus one clocks
	always_ff @(posedge clk)
	begin
		if (rst | ~ctrl[`CSP_C_CLOCK_DIRECTION])
		begin
			divCnt <= 8'h00;
			genClk <= 1'b0;
		end
		else if (divCnt == sck[`CSP_S_SD])
		begin
			divCnt <= 8'h00;
			genClk <= ~genClk;
		end
		else
			divCnt <= divCnt + 8'h01;
	end

	// pick the shift clock and find its edges
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bitQ    <= 1'b0;
			bitPrev <= 1'b0;
		end
		else
		begin
			bitQ    <= ctrl[`CSP_C_CLOCK_DIRECTION] ? genClk : pinIn.sclk;
			bitPrev <= bitQ;
		end
	end

	assign bitRise = bitQ & ~bitPrev;
	assign bitFall = ~bitQ & bitPrev;
	assign txEdge  = sck[`CSP_S_TES] ? bitFall : bitRise;
	assign rxEdge  = sck[`CSP_S_RES] ? bitRise : bitFall;

	//--------------------------------------------------
	// frame sync
	//--------------------------------------------------
	assign fsTick = ctrl[`CSP_C_FSC] | bitRise;

	// generated sync waveform
	always_comb
	begin
		if (sck[`CSP_S_FRL])
			next_fsGen = (fsCnt == 8'h00);
		else
			next_fsGen = (fsCnt < ((fdMax >> 1) + 8'h01));
	end

	// divisor counter
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fsCnt <= 8'h00;
			fsGen <= 1'b0;
		end
		else
		begin
			if (fsTick)
				fsCnt <= (fsCnt >= fdMax) ? 8'h00 : fsCnt + 8'h01;
			fsGen <= next_fsGen;
		end
	end

	assign fsLvl      = ctrl[`CSP_C_SYNC_DIRECTION] ? fsGen : pinIn.fs;
	assign frameStart = bitRise & (fsLvl != fsSamp)
	                  & (fsLvl | (sck[`CSP_S_WT] == 2'h3));

	// sync sampled on each rising bit clock
	always_ff @(posedge clk)
	begin
		if (rst)
			fsSamp <= 1'b0;
		else if (bitRise)
			fsSamp <= fsLvl;
	end

	//--------------------------------------------------
	// frame sequencer
	//--------------------------------------------------
	// shifting starts on the very edge that ends the delay
	assign inShift = frameStart ? (frm[`CSP_F_DD] == 8'h00)
	               : (state == csp_pkg::CSP_SHIFT)
	               | ((state == csp_pkg::CSP_DELAY) & bitRise
	                  & (dlyCnt == 8'h00));

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state  <= csp_pkg::CSP_IDLE;
			dlyCnt <= 8'h00;
		end
		else if (frameStart)
		begin
			dlyCnt <= frm[`CSP_F_DD] - 8'h01;
			if (frm[`CSP_F_DD] == 8'h00)
				state <= csp_pkg::CSP_SHIFT;
			else
				state <= csp_pkg::CSP_DELAY;
		end
		else
		begin
			case (state)
				csp_pkg::CSP_DELAY:
					if (bitRise)
					begin
						if (dlyCnt == 8'h00)
							state <= csp_pkg::CSP_SHIFT;
						else
							dlyCnt <= dlyCnt - 8'h01;
					end
				csp_pkg::CSP_SHIFT:
					if ((rxWords == words) & (txWords == words)
					    & (txBit == 5'h00))
						state <= csp_pkg::CSP_IDLE;
				default:
					state <= csp_pkg::CSP_IDLE;
			endcase
		end
	end

	//--------------------------------------------------
	// transmitter
	//--------------------------------------------------
	assign txLoad = sck[`CSP_S_DWS] ? txMem[txRd]
	                                : {txMem[txRd][15:0], 16'h0000};
	assign txStart = inShift & txEdge
	               & (frameStart | ((txBit == 5'h00) & (txWords != words)));
	assign txPop   = txStart & ctrl[`CSP_C_TEN] & ~txEmpty;

	// serializer, msb first
	always_ff @(posedge clk)
	begin
		if (rst | (frameStart & ~txStart))
		begin
			txBit    <= 5'h00;
			txWords  <= 2'h0;
			txShift  <= 32'h0000_0000;
			sdoValid <= 1'b0;
			if (rst)
				sdoBit <= 1'b0;
		end
		else if (txStart)
		begin
			txWords  <= (frameStart ? 2'h0 : txWords) + 2'h1;
			txBit    <= 5'h01;
			sdoValid <= txPop;
			sdoBit   <= txPop & txLoad[31];
			txShift  <= txPop ? {txLoad[30:0], 1'b0} : 32'h0000_0000;
		end
		else if ((state != csp_pkg::CSP_SHIFT)
		         | (txEdge & (txBit == 5'h00)))
			sdoValid <= 1'b0;
		else if (txEdge)
		begin
			sdoBit  <= txShift[31];
			txShift <= {txShift[30:0], 1'b0};
			txBit   <= (txBit == lastBit) ? 5'h00 : txBit + 5'h01;
		end
	end

	//--------------------------------------------------
	// receiver
	//--------------------------------------------------
	assign rxIn   = ctrl[`CSP_C_LOOP] ? sdoBit : pinIn.sdi;
	assign rxWord = sck[`CSP_S_DWS] ? {rxShift[30:0], rxIn}
	                                : {16'h0000, rxShift[14:0], rxIn};
	assign rxStep = inShift & rxEdge & (frameStart | (rxWords != words));
	assign rxLast = ~frameStart & (rxBit == lastBit);
	assign rxPush = rxStep & rxLast & ctrl[`CSP_C_REN] & ~rxFull;
	assign rxOvr  = rxStep & rxLast & ctrl[`CSP_C_REN] & rxFull;

	// deserializer
	always_ff @(posedge clk)
	begin
		if (rst | (frameStart & ~rxStep))
		begin
			rxBit   <= 5'h00;
			rxWords <= 2'h0;
			rxShift <= 32'h0000_0000;
		end
		else if (rxStep)
		begin
			rxShift <= {rxShift[30:0], rxIn};
			if (rxLast)
			begin
				rxBit   <= 5'h00;
				rxWords <= rxWords + 2'h1;
			end
			else
			begin
				rxBit   <= (frameStart ? 5'h00 : rxBit) + 5'h01;
				rxWords <= frameStart ? 2'h0 : rxWords;
			end
		end
	end

	//--------------------------------------------------
	// status flags and interrupt
	//--------------------------------------------------
	assign cond = {1'b0, 1'b0,
	               rxCnt >= (PTRW+1)'(fpsLevel),
	               rxFull, rxEmpty, txFull, txEmpty};
	assign sets = {rxOvr, txOvr, cond[4:0] & ~prevCond[4:0]};

	// sticky flags, a new event beats the read clear
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			flags    <= 7'h00;
			prevCond <= 7'h05;
		end
		else
		begin
			prevCond <= cond;
			if (apbDone & ~pwrite & (regIdx == `CSP_IDX_STS))
				flags <= (flags & ~snap) | sets;
			else
				flags <= flags | sets;
		end
	end

	// masked request
	always_ff @(posedge clk)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(flags & {ctrl[`CSP_C_IRO], ctrl[`CSP_C_ITO],
			                  ctrl[`CSP_C_IRS], ctrl[`CSP_C_IRF],
			                  ctrl[`CSP_C_IRE], ctrl[`CSP_C_ITF],
			                  ctrl[`CSP_C_ITE]});
	end

	//--------------------------------------------------
	// pin drivers
	//--------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			pinOut <= 6'b010101;
		else
		begin
			pinOut.sclk    <= genClk;
			pinOut.sclkOeN <= ~ctrl[`CSP_C_CLOCK_DIRECTION];
			pinOut.fs      <= fsGen;
			pinOut.fsOeN   <= ~ctrl[`CSP_C_SYNC_DIRECTION];
			pinOut.sdo     <= sdoBit;
			pinOut.sdoOeN  <= ctrl[`CSP_C_OUT_FLOAT] & ~sdoValid;
		end
	end
endmodule : csp_codec_port

// File: csp_port_checker.sv
`timescale 1ns/100ps
`include "csp_cfg.svh"
module csp_port_checker #(
	parameter int DEPTH = 4,
	parameter int PTRW  = 2
)(
	// system
	input wire logic                  clk,
	input wire logic                  rst,
	// apb
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [17:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pready,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// pins and interrupt
	input wire csp_pkg::csp_pin_in_t  pinIn,
	input wire csp_pkg::csp_pin_out_t pinOut,
	input wire logic                  irq
);
	// --------
	// shadow state
	// --------
	logic        sclkD, hv;
	wire [15:0]  idx = paddr[17:2];
	wire         wr  = psel && penable && pready && pwrite;
	wire         tog = pinOut.sclk != sclkD;
	wire         mapped = idx inside {`CSP_IDX_CTRL, `CSP_IDX_FRM,
		`CSP_IDX_SCK, `CSP_IDX_STS, `CSP_IDX_TX, `CSP_IDX_RX};
	logic [15:0] ctrl, sck;
	logic [2:0]  since;
	logic [8:0]  tcnt;

	// register copies taken at write completion
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl <= `CSP_RST_CTRL;
			sck  <= `CSP_RST_SCK;
		end
		else if (wr && idx == `CSP_IDX_CTRL)
			ctrl <= pwdata[15:0];
		else if (wr && idx == `CSP_IDX_SCK)
			sck <= pwdata[15:0];
	end

	// settle time since last control write
	always_ff @(posedge clk)
	begin
		if (rst)
			since <= 3'h7;
		else if (wr && idx == `CSP_IDX_CTRL)
			since <= 3'h0;
		else if (since != 3'h7)
			since <= since + 3'h1;
	end

	// cycles between bit clock toggles
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sclkD <= 1'b0;
			tcnt  <= 9'h0;
			hv    <= 1'b0;
		end
		else
		begin
			sclkD <= pinOut.sclk;
			tcnt  <= tog ? 9'h1 : tcnt + 9'h1;
			if (wr && (idx == `CSP_IDX_SCK || idx == `CSP_IDX_CTRL))
				hv <= 1'b0;
			else if (tog)
				hv <= 1'b1;
		end
	end

	// --------
	// properties
	// --------
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_ready;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("apb answer timing wrong");
	property p_err;
		pready |-> pslverr == !mapped;
	endproperty
	a_err: assert property (p_err)
		else $error("slave error wrong");
	property p_hi;
		pready && !pwrite |-> prdata[31:16] == 16'h0
			&& (idx != `CSP_IDX_STS || prdata[15:7] == 9'h0);
	endproperty
	a_hi: assert property (p_hi)
		else $error("unused read bits set");
	property p_sclk;
		since == 3'h7 |-> pinOut.sclkOeN == !ctrl[`CSP_C_CLOCK_DIRECTION];
	endproperty
	a_sclk: assert property (p_sclk)
		else $error("bit clock direction wrong");
	property p_fs;
		since == 3'h7 |-> pinOut.fsOeN == !ctrl[`CSP_C_SYNC_DIRECTION];
	endproperty
	a_fs: assert property (p_fs)
		else $error("sync direction wrong");
	property p_float;
		since == 3'h7 && pinOut.sdoOeN |-> ctrl[`CSP_C_OUT_FLOAT];
	endproperty
	a_float: assert property (p_float)
		else $error("output floated while forced");
	property p_irq;
		since == 3'h7 && irq |-> ctrl[8:2] != 7'h0;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt with all masked");
	property p_half;
		tog && hv && !pinOut.sclkOeN |-> tcnt == {1'b0, sck[7:0]} + 9'h1;
	endproperty
	a_half: assert property (p_half)
		else $error("bit clock half period wrong");

	c_wr: cover property (wr && idx == `CSP_IDX_CTRL);
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
endmodule : csp_port_checker

// File: csp_codec_model.sv
`timescale 1ns/100ps
module csp_codec_model #(
	parameter int HALF = 8
)(
	// system
	input wire logic        clk,
	// frame request
	input wire logic        go,
	input wire logic        wide,
	input wire logic [31:0] word,
	output logic            busy,
	output logic [31:0]     heard,
	// codec wires
	input wire logic        sdo,
	output logic            sclk,
	output logic            fs,
	output logic            sdi
);
	int n;

	// codec as clock master, clock still between frames
	initial
	begin
		sclk = 1'b0;
		fs = 1'b0;
		sdi = 1'b0;
		busy = 1'b0;
		heard = 32'h0;
		forever
		begin
			@(posedge clk);
			if (go)
			begin
				busy <= 1'b1;
				for (n = wide ? 31 : 15; n >= 0; n--)
				begin
					sclk <= 1'b1;
					fs   <= n == (wide ? 31 : 15);
					sdi  <= word[n];
					repeat (HALF) @(posedge clk);
					heard <= {heard[30:0], sdo};
					sclk  <= 1'b0;
					repeat (HALF) @(posedge clk);
				end
				fs   <= 1'b0;
				busy <= 1'b0;
			end
			else
				sdi <= ~sdi; // released line keeps moving
		end
	end
endmodule : csp_codec_model

// File: tb_codec_serial_port.sv
`timescale 1ns/100ps
`include "csp_cfg.svh"
module tb_codec_serial_port;
	localparam int DEPTH = 4;
	localparam int PTRW  = 2;
	logic                  clk, rst, psel, penable, pwrite, go, wide;
	logic                  pready, pslverr, irq, busy, mSclk, mFs, mSdi, err;
	logic [17:0]           paddr;
	logic [31:0]           pwdata, prdata, word, heard, seed, rd;
	logic [15:0]           tq[2], rq[2];
	csp_pkg::csp_pin_in_t  pinIn;
	csp_pkg::csp_pin_out_t pinOut;
	int                    num_errors, check_count, i, n;

	// wire levels from the port's enables
	assign pinIn = {pinOut.sclkOeN ? mSclk : pinOut.sclk,
		pinOut.fsOeN ? mFs : pinOut.fs, mSdi};

	csp_codec_port #(.DEPTH(DEPTH), .PTRW(PTRW)) csp_codec_port_i (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pinIn(pinIn),
		.pinOut(pinOut), .irq(irq));
	csp_codec_model csp_codec_model_i (
		.clk(clk), .go(go), .wide(wide), .word(word), .busy(busy),
		.heard(heard), .sdo(pinOut.sdo), .sclk(mSclk), .fs(mFs),
		.sdi(mSdi));

	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// --------
	// bench helpers
	// --------
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// one apb transfer, held until pready
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
			if (k == 40)
			begin
				num_errors++;
				tally_and_finish;
			end
		end
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdc(input logic [15:0] idx, input logic [31:0] exp,
		input logic [31:0] m = 32'hffffffff);
		apb(1'b0, idx, 32'h0);
		cmp(rd & m, exp & m);
	endtask : rdc

	// one codec frame, waited out under a bound
	task frame(input logic wd, input logic [31:0] w);
		int k;
		@(posedge clk);
		go   <= 1'b1;
		wide <= wd;
		word <= w;
		@(posedge clk);
		go <= 1'b0;
		for (k = 0; busy !== 1'b0 || k < 2; k++)
		begin
			if (k == 4000)
			begin
				num_errors++;
				tally_and_finish;
			end
			@(negedge clk);
		end
	endtask : frame

	function logic sig(input logic f);
		return f ? pinOut.fs : pinOut.sclk;
	endfunction : sig

	// length of one full phase at level lvl
	task span(input logic f, input logic lvl, output int c);
		int k;
		for (k = 0; k < 999 && sig(f) !== ~lvl; k++)
			@(negedge clk);
		for (k = 0; k < 999 && sig(f) !== lvl; k++)
			@(negedge clk);
		for (c = 0; c < 999 && sig(f) === lvl; c++)
			@(negedge clk);
	endtask : span

	// --------
	// main sequence
	// --------
	initial
	begin
		{rst, psel, penable, pwrite, go, wide} = 6'h20;
		{paddr, pwdata, word} = 82'h0;
		seed = 32'h4cd2b943;
		num_errors = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// reset values and refused places
		cmp(pinOut.sdoOeN, 32'h1);
		rdc(`CSP_IDX_CTRL, `CSP_RST_CTRL);
		rdc(`CSP_IDX_FRM, `CSP_RST_FRM);
		rdc(`CSP_IDX_SCK, `CSP_RST_SCK);
		rdc(`CSP_IDX_STS, 32'h0);
		rdc(`CSP_IDX_TX, 32'h0);
		rdc(`CSP_IDX_RX, 32'h0);
		rdc(16'hec0c, 32'h0);
		cmp(err, 32'h1);
		// random write and read back
		for (i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			apb(1'b1, `CSP_IDX_CTRL, seed[15:0] & 16'h09fc);
			rdc(`CSP_IDX_CTRL, seed[15:0] & 16'h09fc);
			apb(1'b1, `CSP_IDX_FRM, seed[31:16]);
			rdc(`CSP_IDX_FRM, seed[31:16]);
			apb(1'b1, `CSP_IDX_SCK, seed[15:0] ^ seed[31:16]);
			rdc(`CSP_IDX_SCK, seed[15:0] ^ seed[31:16]);
		end
		apb(1'b1, `CSP_IDX_FRM, `CSP_RST_FRM);
		apb(1'b1, `CSP_IDX_SCK, `CSP_RST_SCK);
		// external clock, two 16-bit words each way
		apb(1'b1, `CSP_IDX_CTRL, 32'h0083);
		for (i = 0; i < 2; i++)
		begin
			seed = lfsr(seed);
			tq[i] = i ? seed[15:0] : 16'h8001;
			rq[i] = seed[31:16];
			apb(1'b1, `CSP_IDX_TX, tq[i]);
		end
		for (i = 0; i < 2; i++)
		begin
			frame(1'b0, rq[i]);
			cmp(heard[15:0], tq[i]);
			cmp(irq, i);
		end
		rdc(`CSP_IDX_STS, 32'h10, 32'h10);
		rdc(`CSP_IDX_STS, 32'h0, 32'h10);
		for (i = 0; i < 2; i++)
			rdc(`CSP_IDX_RX, rq[i]);
		// loopback with 32-bit words in halves
		apb(1'b1, `CSP_IDX_SCK, 32'h481f);
		apb(1'b1, `CSP_IDX_CTRL, 32'h2003);
		seed = lfsr(seed);
		apb(1'b1, `CSP_IDX_TX, seed[31:16]);
		apb(1'b1, `CSP_IDX_TX, seed[15:0]);
		frame(1'b1, ~seed);
		rdc(`CSP_IDX_RX, seed[31:16]);
		rdc(`CSP_IDX_RX, seed[15:0]);
		// transmit overrun with transmitter off
		apb(1'b1, `CSP_IDX_SCK, `CSP_RST_SCK);
		apb(1'b1, `CSP_IDX_CTRL, 32'h0810);
		for (i = 0; i <= DEPTH; i++)
			apb(1'b1, `CSP_IDX_TX, i);
		for (i = 0; i < 20 && irq !== 1'b1; i++)
			@(negedge clk);
		cmp(irq, 32'h1);
		rdc(`CSP_IDX_STS, 32'h27, 32'h7f);
		rdc(`CSP_IDX_STS, 32'h0, 32'h7f);
		// generated clock and sync
		apb(1'b1, `CSP_IDX_FRM, 32'h0004);
		apb(1'b1, `CSP_IDX_SCK, 32'h0403);
		apb(1'b1, `CSP_IDX_CTRL, 32'h0600);
		span(1'b0, 1'b1, n);
		cmp(n, 32'd4);
		span(1'b1, 1'b1, n);
		cmp(n, 32'd8);
		span(1'b1, 1'b0, n);
		cmp(n, 32'd24);
		apb(1'b1, `CSP_IDX_CTRL, 32'h1600);
		span(1'b1, 1'b1, n);
		cmp(n, 32'd1);
		span(1'b1, 1'b0, n);
		cmp(n, 32'd3);
		tally_and_finish;
	end
endmodule : tb_codec_serial_port

bind csp_codec_port csp_port_checker #(
	.DEPTH(DEPTH), .PTRW(PTRW)
) csp_port_checker_i (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .pinIn(pinIn),
	.pinOut(pinOut), .irq(irq));
